// file: pkg/hsc_pkg.sv
package hsc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          FILT_60K_NS   = 2500;
    localparam int          FILT_100K_NS  = 1500;
    // Least filter times, rounded up to whole cycles
    localparam logic [7:0]  FILT_60K_CYC  = 8'((FILT_60K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0]  FILT_100K_CYC = 8'((FILT_100K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0]  A_CTRL      = 8'h00;
    localparam logic [7:0]  A_STAT      = 8'h04;
    localparam logic [3:0]  A_CFG_PAGE  = 4'h1;
    localparam logic [3:0]  A_RMAX_PAGE = 4'h2;
    localparam logic [3:0]  A_CNT_PAGE  = 4'h3;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int          CTRL_RESTART_BIT = 0;
    localparam int          CTRL_SWRST_LSB   = 8;
    localparam int          CFG_USE_LSB      = 0;
    localparam int          CFG_RING_BIT     = 2;
    localparam int          CFG_RSTM_BIT     = 3;
    localparam int          CFG_CMP_BIT      = 4;
    localparam int          CFG_MODE_LSB     = 5;
    localparam logic [31:0] CFG_RST          = 32'h0000_0001;
    localparam logic [31:0] RMAX_RST         = 32'h0000_0000;
    localparam logic [31:0] RING_TOP         = 32'hFFFF_FFFF;

    // ----------------------------------------------------------------
    // Terminal bit positions within the input word
    // ----------------------------------------------------------------
    localparam logic [3:0]  TB_A_EVEN = 4'h8;
    localparam logic [3:0]  TB_B_EVEN = 4'h9;
    localparam logic [3:0]  TB_Z_EVEN = 4'h3;
    localparam logic [3:0]  TB_A_ODD  = 4'h6;
    localparam logic [3:0]  TB_B_ODD  = 4'h7;
    localparam logic [3:0]  TB_Z_ODD  = 4'h2;

    typedef enum logic [1:0] {HSC_OFF, HSC_60K, HSC_100K, HSC_RSVD} hsc_use_e;
    typedef enum logic [1:0] {HSC_QUAD, HSC_PDIR, HSC_UPDN, HSC_INCR} hsc_mode_e;

endpackage

// file: core/hsc_counter_top.sv
// Operation
// - Each counter is off, filtered for 60 kHz, or filtered for 100 kHz, the choice setting the noise filter length.
// - Ring mode takes a 32-bit ring maximum for each counter.
// - A ring maximum of zero acts as FFFF FFFF.
// - Linear counting uses the full 32 bits, signed range or unsigned in increment mode, wrapping freely.
// - Each counter resets either by phase Z while its software reset bit is on, or by the software bit alone.
// - Under the combined method a rising phase Z with the software bit on clears the count.
// - Under the software method turning the software bit on clears the count.
// - A per-counter option stops or keeps comparison running after a counter reset.
// - Four input modes: quadrature, pulse plus direction, up/down pulses, increment; increment frees terminal B.
// - Counters 0 and 2 use bits 8, 9, 3 and counters 1 and 3 use bits 6, 7, 2 of their input word.
// - A terminal not claimed by a counter stays usable for the other input functions.
// - An enabled counter 1 withdraws bits 2 and 6 of word 0, and bit 7 outside increment mode, from the other input functions.
// - Configuration takes effect only at reset or restart, never on a plain write.
module hsc_counter_top (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic      [31:0] HRDATA,
    input  wire logic [15:0] IO_WORD0,
    input  wire logic [15:0] IO_WORD1,
    output logic      [15:0] FREE_WORD0,
    output logic      [15:0] FREE_WORD1,
    output logic      [3:0]  CMP_RUN
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [31:0] cfg_stage_r [4], rmax_stage_r [4], cfg_act_r [4], rmax_act_r [4], cnt_r [4];
    logic [7:0]  fcnt_r      [4][3];
    logic [2:0]  raw         [4], filt_r [4], prev_r [4];
    logic [3:0]  swrst_r, swrst_prev_r, en, up_ev, dn_ev, clr, cmp_run_r;
    logic [15:0] claim0, claim1;
    logic        restart, ap_valid_r, ap_write_r, ap_take;
    logic [7:0]  ap_addr_r;
    logic [31:0] hrdata_r;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Terminal bit k (0 = A, 1 = B, 2 = Z) of counter i
    function automatic logic [3:0] term_bit(input int i, input int k);
        logic odd;
        odd = (i % 2) == 1;
        case (k)
            0:       term_bit = odd ? hsc_pkg::TB_A_ODD : hsc_pkg::TB_A_EVEN;
            1:       term_bit = odd ? hsc_pkg::TB_B_ODD : hsc_pkg::TB_B_EVEN;
            default: term_bit = odd ? hsc_pkg::TB_Z_ODD : hsc_pkg::TB_Z_EVEN;
        endcase
    endfunction
    // Zero in the ring maximum stands for the full range
    function automatic logic [31:0] ring_eff(input logic [31:0] m);
        ring_eff = (m == 32'h0000_0000) ? hsc_pkg::RING_TOP : m;
    endfunction
    function automatic hsc_pkg::hsc_use_e use_of(input logic [31:0] c);
        use_of = hsc_pkg::hsc_use_e'(c[hsc_pkg::CFG_USE_LSB +: 2]);
    endfunction
    function automatic hsc_pkg::hsc_mode_e mode_of(input logic [31:0] c);
        mode_of = hsc_pkg::hsc_mode_e'(c[hsc_pkg::CFG_MODE_LSB +: 2]);
    endfunction

    // ----------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ----------------------------------------------------------------
    assign ap_take   = HSEL && HTRANS[1] && HREADY;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = hrdata_r;
    assign restart   = ap_valid_r && ap_write_r && (ap_addr_r == hsc_pkg::A_CTRL)
                       && HWDATA[hsc_pkg::CTRL_RESTART_BIT];
    // Address phase capture; read data is prepared here so it stands in the data phase
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r  <= 8'h00;
            hrdata_r   <= 32'h0000_0000;
        end else begin
            ap_valid_r <= ap_take;
            ap_write_r <= HWRITE;
            ap_addr_r  <= HADDR[7:0];
            if (ap_take && !HWRITE) begin
                hrdata_r <= 32'h0000_0000;
                if (HADDR[7:0] == hsc_pkg::A_CTRL)
                    hrdata_r[hsc_pkg::CTRL_SWRST_LSB +: 4] <= swrst_r;
                else if (HADDR[7:0] == hsc_pkg::A_STAT)
                    hrdata_r <= {20'h00000, claim0[9:6] != 4'h0, cmp_run_r, en, 3'h0};
                else if (HADDR[7:4] == hsc_pkg::A_CFG_PAGE)
                    hrdata_r <= cfg_stage_r[HADDR[3:2]];
                else if (HADDR[7:4] == hsc_pkg::A_RMAX_PAGE)
                    hrdata_r <= rmax_stage_r[HADDR[3:2]];
                else if (HADDR[7:4] == hsc_pkg::A_CNT_PAGE)
                    hrdata_r <= cnt_r[HADDR[3:2]];
            end
        end
    end
    // Staged settings and software reset bits; staging never touches the live counters
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            swrst_r <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                cfg_stage_r[i]  <= hsc_pkg::CFG_RST;
                rmax_stage_r[i] <= hsc_pkg::RMAX_RST;
            end
        end else if (ap_valid_r && ap_write_r) begin
            if (ap_addr_r == hsc_pkg::A_CTRL)
                swrst_r <= HWDATA[hsc_pkg::CTRL_SWRST_LSB +: 4];
            else if (ap_addr_r[7:4] == hsc_pkg::A_CFG_PAGE)
                cfg_stage_r[ap_addr_r[3:2]] <= HWDATA;
            else if (ap_addr_r[7:4] == hsc_pkg::A_RMAX_PAGE)
                rmax_stage_r[ap_addr_r[3:2]] <= HWDATA;
        end
    end

    // ----------------------------------------------------------------
    // Live configuration: loaded only at reset or restart
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < 4; i++) begin
                cfg_act_r[i]  <= hsc_pkg::CFG_RST;
                rmax_act_r[i] <= hsc_pkg::RMAX_RST;
            end
        end else if (restart) begin
            for (int i = 0; i < 4; i++) begin
                cfg_act_r[i]  <= cfg_stage_r[i];
                rmax_act_r[i] <= rmax_stage_r[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Noise filter: a terminal follows its pin once it held steady long enough
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || restart) begin
            for (int i = 0; i < 4; i++) begin
                filt_r[i] <= 3'h0;
                prev_r[i] <= 3'h0;
                for (int k = 0; k < 3; k++)
                    fcnt_r[i][k] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                prev_r[i] <= filt_r[i];
                for (int k = 0; k < 3; k++) begin
                    if (raw[i][k] == filt_r[i][k])
                        fcnt_r[i][k] <= 8'h00;
                    else if (fcnt_r[i][k] + 8'h01 >= ((use_of(cfg_act_r[i]) == hsc_pkg::HSC_100K)
                             ? hsc_pkg::FILT_100K_CYC : hsc_pkg::FILT_60K_CYC)) begin
                        fcnt_r[i][k]    <= 8'h00;
                        filt_r[i][k]    <= raw[i][k];
                    end else
                        fcnt_r[i][k] <= fcnt_r[i][k] + 8'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Edge decoding, reset requests and terminal claims
    // ----------------------------------------------------------------
    always_comb begin
        claim0 = 16'h0000;
        claim1 = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 3; k++)
                raw[i][k] = (i < 2) ? IO_WORD0[term_bit(i, k)] : IO_WORD1[term_bit(i, k)];
            en[i]    = use_of(cfg_act_r[i]) == hsc_pkg::HSC_60K || use_of(cfg_act_r[i]) == hsc_pkg::HSC_100K;
            up_ev[i] = 1'b0;
            dn_ev[i] = 1'b0;
            case (mode_of(cfg_act_r[i]))
                hsc_pkg::HSC_QUAD: begin
                    // A changing to differ from B, or B changing to match A, means A leads
                    up_ev[i] = (filt_r[i][0] ^ prev_r[i][0]) & (filt_r[i][0] ^ filt_r[i][1])
                             | (filt_r[i][1] ^ prev_r[i][1]) & (filt_r[i][0] ~^ filt_r[i][1]);
                    dn_ev[i] = (filt_r[i][0] ^ prev_r[i][0]) & (filt_r[i][0] ~^ filt_r[i][1])
                             | (filt_r[i][1] ^ prev_r[i][1]) & (filt_r[i][0] ^ filt_r[i][1]);
                end
                hsc_pkg::HSC_PDIR: begin
                    up_ev[i] = filt_r[i][0] & ~prev_r[i][0] & filt_r[i][1];
                    dn_ev[i] = filt_r[i][0] & ~prev_r[i][0] & ~filt_r[i][1];
                end
                hsc_pkg::HSC_UPDN: begin
                    up_ev[i] = filt_r[i][0] & ~prev_r[i][0];
                    dn_ev[i] = filt_r[i][1] & ~prev_r[i][1];
                end
                default: up_ev[i] = filt_r[i][0] & ~prev_r[i][0];
            endcase
            up_ev[i] = up_ev[i] & en[i];
            dn_ev[i] = dn_ev[i] & en[i];
            // Combined method wants the software bit held; software method wants its rising edge
            clr[i] = en[i] & (cfg_act_r[i][hsc_pkg::CFG_RSTM_BIT]
                     ? (swrst_r[i] & ~swrst_prev_r[i])
                     : (filt_r[i][2] & ~prev_r[i][2] & swrst_r[i]));
            if (en[i]) begin
                // Increment mode leaves terminal B to the other input functions
                if (i < 2) begin
                    claim0[term_bit(i, 0)] = 1'b1;
                    claim0[term_bit(i, 2)] = 1'b1;
                    claim0[term_bit(i, 1)] = mode_of(cfg_act_r[i]) != hsc_pkg::HSC_INCR;
                end else begin
                    claim1[term_bit(i, 0)] = 1'b1;
                    claim1[term_bit(i, 2)] = 1'b1;
                    claim1[term_bit(i, 1)] = mode_of(cfg_act_r[i]) != hsc_pkg::HSC_INCR;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Counters, compare gating and freed terminals
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || restart) begin
            swrst_prev_r <= 4'h0;
            cmp_run_r    <= 4'hF;
            FREE_WORD0   <= 16'h0000;
            FREE_WORD1   <= 16'h0000;
            for (int i = 0; i < 4; i++)
                cnt_r[i] <= 32'h0000_0000;
        end else begin
            swrst_prev_r <= swrst_r;
            FREE_WORD0   <= IO_WORD0 & ~claim0;
            FREE_WORD1   <= IO_WORD1 & ~claim1;
            for (int i = 0; i < 4; i++) begin
                if (clr[i]) begin
                    cnt_r[i] <= 32'h0000_0000;
                    if (!cfg_act_r[i][hsc_pkg::CFG_CMP_BIT])
                        cmp_run_r[i] <= 1'b0;
                end else if (up_ev[i] && !dn_ev[i]) begin
                    // Linear mode simply rolls over the 32-bit range
                    if (cfg_act_r[i][hsc_pkg::CFG_RING_BIT] && cnt_r[i] >= ring_eff(rmax_act_r[i]))
                        cnt_r[i] <= 32'h0000_0000;
                    else
                        cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
                end else if (dn_ev[i] && !up_ev[i]) begin
                    if (cfg_act_r[i][hsc_pkg::CFG_RING_BIT] && cnt_r[i] == 32'h0000_0000)
                        cnt_r[i] <= ring_eff(rmax_act_r[i]);
                    else
                        cnt_r[i] <= cnt_r[i] - 32'h0000_0001;
                end
            end
        end
    end

    assign CMP_RUN = cmp_run_r & en;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    // Each check watches the counter that the bench drives into that situation
    AST_RING_WRAP_UP: assert property (!restart && up_ev[2] && !dn_ev[2] && !clr[2] && cfg_act_r[2][2]
        && cnt_r[2] == ring_eff(rmax_act_r[2]) |=> cnt_r[2] == 32'h0000_0000)
        else $error("ring did not wrap to zero");
    AST_RING_WRAP_DN: assert property (!restart && dn_ev[2] && !up_ev[2] && !clr[2] && cfg_act_r[2][2]
        && cnt_r[2] == 32'h0000_0000 |=> cnt_r[2] == $past(ring_eff(rmax_act_r[2])))
        else $error("ring did not wrap to maximum");
    AST_ZERO_MAX: assert property (!restart && dn_ev[3] && !up_ev[3] && !clr[3] && cfg_act_r[3][2]
        && rmax_act_r[3] == 32'h0000_0000 && cnt_r[3] == 32'h0000_0000 |=> cnt_r[3] == 32'hFFFF_FFFF)
        else $error("zero maximum not treated as full range");
    AST_SW_RESET: assert property (!restart && en[2] && cfg_act_r[2][3] && $rose(swrst_r[2])
        |=> cnt_r[2] == 32'h0000_0000)
        else $error("software reset did not clear count");
    AST_Z_RESET: assert property (!restart && en[3] && !cfg_act_r[3][3] && swrst_r[3] && filt_r[3][2]
        && !prev_r[3][2] |=> cnt_r[3] == 32'h0000_0000)
        else $error("phase Z reset did not clear count");
    AST_CFG_HOLD: assert property (!restart |=> $stable(cfg_act_r[0]) && $stable(rmax_act_r[0]))
        else $error("live configuration changed without restart");
    AST_OFF_IDLE: assert property (!restart && !en[0] |=> $stable(cnt_r[0]))
        else $error("unused counter moved");
    AST_CLAIM1: assert property (!restart && en[1] ##1 !restart |-> FREE_WORD0[2] == 1'b0
        && FREE_WORD0[6] == 1'b0 && (FREE_WORD0[7] == 1'b0 || $past(mode_of(cfg_act_r[1])) == hsc_pkg::HSC_INCR))
        else $error("counter 1 terminals leaked to other functions");
    AST_QUAD_UP: assert property (!restart && en[0] && !clr[0] && mode_of(cfg_act_r[0]) == hsc_pkg::HSC_QUAD
        && !cfg_act_r[0][2] && $rose(filt_r[0][0]) && !filt_r[0][1] ##1 !restart
        |-> cnt_r[0] == $past(cnt_r[0]) + 32'h0000_0001)
        else $error("quadrature up step missing");
    AST_CMP_STOP: assert property (!restart && clr[2] && !cfg_act_r[2][4] |=> !cmp_run_r[2])
        else $error("compare kept running after reset");
    COV_QUAD_UP:  cover property (up_ev[0] && mode_of(cfg_act_r[0]) == hsc_pkg::HSC_QUAD);
    COV_RING:     cover property (cfg_act_r[2][2] && dn_ev[2] && cnt_r[2] == 32'h0000_0000);
    COV_SW_CLR:   cover property (clr[2] && cfg_act_r[2][3]);
    COV_RESTART:  cover property (restart);
endmodule

// file: verification/hsc_pulse_src.sv
// ----------------------------------------------------------------
// Pulse and encoder source for one input word
// ----------------------------------------------------------------
module hsc_pulse_src (
    input  wire logic        clk,
    output logic      [15:0] word
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle low so no count or reset edge is seen before the bench asks
    initial word = 16'h0000;

    // Whole word change, held long enough to pass either filter
    task automatic set_word(input logic [15:0] v, input int hold);
        @(posedge clk);
        word <= v;
        repeat (hold) @(posedge clk);
    endtask

    // One terminal high then low; width below the filter length is dropped by the device
    task automatic pulse(input int b, input int width);
        @(posedge clk);
        word[b] <= 1'b1;
        repeat (width) @(posedge clk);
        word[b] <= 1'b0;
        repeat (width) @(posedge clk);
    endtask

    // Gray steps 00,10,11,01: stepping forward makes phase A lead phase B
    task automatic quad(input int a, input int b, input logic up, input int n);
        logic [1:0] g [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
        int         k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            for (int j = 0; j < 4; j++) if (g[j] == {word[a], word[b]}) k = j;
            k = up ? (k + 1) % 4 : (k + 3) % 4;
            @(posedge clk);
            word[a] <= g[k][1];
            word[b] <= g[k][0];
            repeat (30) @(posedge clk);
        end
    endtask
endmodule

// file: verification/hs_counter_input_config_tb_top.sv
module hs_counter_input_config_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        CORE_CLK, SYS_RST, HSEL, HWRITE, HREADYOUT, HRESP;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    logic [15:0] IO_WORD0, IO_WORD1, FREE_WORD0, FREE_WORD1;
    logic [3:0]  CMP_RUN;
    int          err_total, compares, cyc;

    // ----------------------------------------------------------------
    // Device and terminal sources
    // ----------------------------------------------------------------
    hsc_counter_top DUT (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .IO_WORD0(IO_WORD0),
        .IO_WORD1(IO_WORD1), .FREE_WORD0(FREE_WORD0), .FREE_WORD1(FREE_WORD1), .CMP_RUN(CMP_RUN));
    hsc_pulse_src W0 (.clk(CORE_CLK), .word(IO_WORD0));
    hsc_pulse_src W1 (.clk(CORE_CLK), .word(IO_WORD1));

    // 10 MHz clock
    initial begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end

    // ----------------------------------------------------------------
    // Bus access and checking
    // ----------------------------------------------------------------
    // Single word transfer; waits on the slave's ready, never on a fixed count
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CORE_CLK);
        HSEL   <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= w;
        HSIZE  <= 3'b010;
        HADDR  <= {24'h000000, a};
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        HSEL   <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= wd;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask

    function automatic logic [7:0] ra(input logic [3:0] page, input int i);
        return {page, 2'(i), 2'b00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    task automatic print_verdict;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard, far above the roughly 800 cycles the tests need
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict;
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {HSEL, HWRITE, HTRANS, HSIZE, HADDR, HWDATA} = '0;
        SYS_RST = 1'b1;
        repeat (20) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rchk(ra(hsc_pkg::A_CFG_PAGE, i), hsc_pkg::CFG_RST);
            rchk(ra(hsc_pkg::A_RMAX_PAGE, i), hsc_pkg::RMAX_RST);
        end
        rchk(8'h0C, 32'h00000000);
        ahb(1'b0, hsc_pkg::A_STAT, 32'h0);
        chk({28'h0, rd[6:3]}, 32'hF);
        chk({28'h0, CMP_RUN}, 32'hF);
        chk({31'h0, HRESP}, 32'h0);
        $display("test reset values done");
        // Counter 0 quadrature: four up, two down
        W0.quad(8, 9, 1'b1, 4);
        W0.quad(8, 9, 1'b0, 2);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 0), 32'h2);
        $display("test quadrature done");
        // Staged setup: 0 off, 1 increment 100k, 2 ring up/down, 3 ring pulse+dir
        ahb(1'b1, ra(hsc_pkg::A_CFG_PAGE, 0), 32'h00);
        ahb(1'b1, ra(hsc_pkg::A_CFG_PAGE, 1), 32'h62);
        ahb(1'b1, ra(hsc_pkg::A_CFG_PAGE, 2), 32'h4D);
        ahb(1'b1, ra(hsc_pkg::A_RMAX_PAGE, 2), 32'h3);
        ahb(1'b1, ra(hsc_pkg::A_CFG_PAGE, 3), 32'h35);
        ahb(1'b1, ra(hsc_pkg::A_RMAX_PAGE, 3), 32'h0);
        ahb(1'b0, hsc_pkg::A_STAT, 32'h0);
        chk({28'h0, rd[6:3]}, 32'hF);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 0), 32'h2);
        ahb(1'b1, hsc_pkg::A_CTRL, 32'h1);
        ahb(1'b0, hsc_pkg::A_STAT, 32'h0);
        chk({28'h0, rd[6:3]}, 32'hE);
        chk({28'h0, CMP_RUN}, 32'hE);
        $display("test restart latch done");
        // Terminal sharing: counter 1 keeps its count and reset bits, frees bit 7
        W0.set_word(16'h03CC, 35);
        chk({16'h0, FREE_WORD0}, 32'h0388);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 1), 32'h1);
        W0.set_word(16'h0300, 35);
        chk({16'h0, FREE_WORD0}, 32'h0300);
        $display("test terminal sharing done");
        // Short pulse passes the 100k filter but not the 60k one
        W0.pulse(6, 20);
        W1.pulse(8, 20);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 1), 32'h2);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 2), 32'h0);
        $display("test filter classes done");
        // Ring wrap both ways, and a zero maximum acting as all ones
        W1.pulse(9, 30);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 2), 32'h3);
        W1.pulse(8, 30);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 2), 32'h0);
        W1.pulse(8, 30);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 2), 32'h1);
        W1.pulse(6, 30);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 3), 32'hFFFFFFFF);
        $display("test ring wrap done");
        // Software clear stops compare; Z clear needs the bit and keeps compare
        ahb(1'b1, hsc_pkg::A_CTRL, 32'h400);
        repeat (3) @(posedge CORE_CLK);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 2), 32'h0);
        chk({28'h0, CMP_RUN}, 32'hA);
        ahb(1'b1, hsc_pkg::A_CTRL, 32'hC00);
        repeat (3) @(posedge CORE_CLK);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 3), 32'hFFFFFFFF);
        W1.pulse(2, 30);
        rchk(ra(hsc_pkg::A_CNT_PAGE, 3), 32'h0);
        chk({28'h0, CMP_RUN}, 32'hA);
        rchk(hsc_pkg::A_CTRL, 32'hC00);
        $display("test counter reset done");
        // Word 1: counter 2 claims bits 8, 9, 3 and counter 3 bits 6, 7, 2
        W1.set_word(16'hF0F0, 35);
        chk({16'h0, FREE_WORD1}, 32'hF030);
        $display("test word 1 sharing done");
        print_verdict;
    end
endmodule
